/* rtl/boost_bypass_mode_sequencer.sv */
// mode, fault and power-good sequencer for a boost regulator with bypass
//
// What this block does
// - circuitry runs only with enable high; enable low means full shutdown.
// - dropping enable forces shutdown at once from any state.
// - enter linear startup when supply is above lockout and enable and bypass pin are high.
// - linear startup phase one limits charge to 1A, phase two to 2A.
// - after linear startup go through startup to soft-start; switching starts.
// - phase two longer than 1024 us leads to the fault state.
// - soft-start not in boost regulation within 2 ms leads to fault.
// - fault isolates input and output, restarts startup after 1 ms.
// - automatic mode moves boost to bypass while input exceeds target.
// - enable high, bypass pin low: forced pass-through, 4000mA limit.
// - enable and bypass pin high: automatic boost or bypass choice.
// - level select picks 3.2V low or 3.4V high, boost and bypass.
// - power-good released high once soft-start has completed.
// - power-good pulled low while any fault or overload is present.
// - power-good low above 120 C, back only below 100 C.
// - overcurrent in high-side on time holds off next pulse.
// - over-temperature latches and stops regulation until below fall.
`timescale 1ns/1ps

module boost_bypass_mode_sequencer #(
    parameter int unsigned LINEAR_START_PHASE_TWO_TIMEOUT_CYCLES =
        seq_pkg::LINEAR_START_PHASE_TWO_TIMEOUT_CYCLES,
    parameter int unsigned SOFT_TIMEOUT_CYCLES =
        seq_pkg::SOFT_TIMEOUT_CYCLES,
    parameter int unsigned RESTART_DELAY_CYCLES =
        seq_pkg::RESTART_DELAY_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // control pins from the host
    input wire logic enable,
    input wire logic force_pass_through_n,
    input wire logic output_level_select,
    // sense inputs from the analog side
    input wire seq_pkg::sense_s sense,
    // power stage controls
    output seq_pkg::power_stage_s power_stage,
    output logic hs_pulse_allow,
    // open-drain power good: out is held low, oe_n low pulls the pin low
    input wire logic power_ok_out_in,
    output logic power_ok_out_o,
    output logic power_ok_out_oe_n,
    output logic irq
);
    import seq_pkg::*;

    state_e state;
    state_e next_state;
    logic [TIMER_W-1:0] timer;
    logic sw_off;
    logic ot_latched;
    logic ocp_holdoff;
    logic power_good;
    logic run_ok;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clear;
    logic [ADDR_W-1:0] addr;
    logic addr_hit;
    logic wr_access;
    logic rd_setup;
    logic linear_start_phase_two_expired;
    logic soft_expired;
    logic restart_due;

    // =====================================================================
    // mode sequencer
    // =====================================================================
    // the enable pin and software switch decide whether anything runs
    assign run_ok = enable && !sw_off;

    assign linear_start_phase_two_expired = timer == TIMER_W'(LINEAR_START_PHASE_TWO_TIMEOUT_CYCLES - 1);
    assign soft_expired = timer == TIMER_W'(SOFT_TIMEOUT_CYCLES - 1);
    assign restart_due = timer == TIMER_W'(RESTART_DELAY_CYCLES - 1);

    // next state; disabling and lockout beat every other step, then forced pass-through beats the automatic steps
    always_comb begin
        next_state = state;
        if (!run_ok) begin
            next_state = st_shutdown;
        end else if (!sense.uvlo_ok) begin
            next_state = st_shutdown;
        end else if (!force_pass_through_n) begin
            next_state = st_pass_through;
        end else begin
            // bypass pin high with enable: automatic mode
            unique case (state)
                st_shutdown, st_pass_through: begin
                    next_state = st_linear_start_phase_one;
                end
                st_linear_start_phase_one: begin
                    if (sense.out_charged) begin
                        next_state = st_startup;
                    end else if (sense.out_half_charged) begin
                        next_state = st_linear_start_phase_two;
                    end
                end
                st_linear_start_phase_two: begin
                    if (sense.out_charged) begin
                        next_state = st_startup;
                    end else if (linear_start_phase_two_expired) begin
                        next_state = st_fault;
                    end
                end
                st_startup: begin
                    next_state = st_soft_start;
                end
                st_soft_start: begin
                    if (sense.ref_ramp_done && sense.out_in_regulation) begin
                        next_state = st_boost;
                    end else if (soft_expired) begin
                        next_state = st_fault;
                    end
                end
                st_boost: begin
                    if (sense.input_above_target) begin
                        next_state = st_bypass;
                    end
                end
                st_bypass: begin
                    if (!sense.input_above_target) begin
                        next_state = st_boost;
                    end
                end
                st_fault: begin
                    if (restart_due) begin
                        next_state = st_linear_start_phase_one;
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= st_shutdown;
        end else begin
            state <= next_state;
        end
    end

    // single time base: restarts on every state change, saturates at top
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer <= '0;
        end else if (next_state != state) begin
            timer <= '0;
        end else if (timer != '1) begin
            timer <= timer + TIMER_W'(1);
        end
    end

    // =====================================================================
    // protections
    // =====================================================================
    // over-temperature latch; a new rise wins over the falling release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ot_latched <= 1'b0;
        end else if (sense.temp_above_rise) begin
            ot_latched <= 1'b1;
        end else if (sense.temp_below_fall) begin
            ot_latched <= 1'b0;
        end
    end

    // cycle-by-cycle hold-off, only sensed while the high side is on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ocp_holdoff <= 1'b0;
        end else if (sense.high_side_on && sense.overcurrent_detect) begin
            ocp_holdoff <= 1'b1;
        end else if (!sense.overcurrent_detect) begin
            ocp_holdoff <= 1'b0;
        end
    end

    // =====================================================================
    // power stage controls, state decodes taken from the next state so they match state; level follows the select pin
    // =====================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_stage <= '0;
            hs_pulse_allow <= 1'b0;
        end else begin
            power_stage.linear_start_phase_one <= next_state == st_linear_start_phase_one;
            power_stage.linear_start_phase_two <= next_state == st_linear_start_phase_two;
            // over-temperature stops all switching regulation
            power_stage.switching_enable <= !ot_latched &&
                (next_state inside {st_soft_start, st_boost});
            power_stage.bypass_switch_on <=
                next_state inside {st_bypass, st_pass_through};
            power_stage.isolate_output <=
                next_state inside {st_fault, st_shutdown};
            power_stage.ref_ramp_enable <= next_state == st_soft_start;
            power_stage.pass_through_limit <= next_state == st_pass_through;
            power_stage.target_level_high <= output_level_select;
            hs_pulse_allow <= !ot_latched && !ocp_holdoff &&
                !(sense.high_side_on && sense.overcurrent_detect) &&
                (next_state inside {st_soft_start, st_boost});
        end
    end

    // =====================================================================
    // power good
    // =====================================================================
    // boost and bypass are reached only through a finished soft-start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_good <= 1'b0;
        end else begin
            power_good <= (state inside {st_boost, st_bypass}) &&
                !ot_latched && !ocp_holdoff;
        end
    end

    // the pin is only ever pulled low; the pull-up makes it high
    assign power_ok_out_o = 1'b0;
    assign power_ok_out_oe_n = power_good;

    // =====================================================================
    // interrupts
    // =====================================================================
    assign irq_event[IRQ_FAULT_BIT] = next_state == st_fault &&
        state != st_fault;
    assign irq_event[IRQ_PG_RISE_BIT] = !power_good &&
        (state inside {st_boost, st_bypass}) && !ot_latched && !ocp_holdoff;
    assign irq_event[IRQ_PG_FALL_BIT] = power_good &&
        !((state inside {st_boost, st_bypass}) && !ot_latched &&
        !ocp_holdoff);
    assign irq_event[IRQ_OT_BIT] = sense.temp_above_rise && !ot_latched;
    assign irq_event[IRQ_OCP_BIT] = sense.high_side_on &&
        sense.overcurrent_detect && !ocp_holdoff;

    assign irq_clear = (wr_access && addr == INT_STAT_ADDR) ?
        pwdata[IRQ_W-1:0] : '0;

    // sticky bits; a new event in the clearing cycle is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clear) | irq_event;
        end
    end

    // level output, high while any unmasked bit is pending
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_stat & ~irq_clear) | irq_event) & irq_mask);
        end
    end

    // =====================================================================
    // apb slave: zero wait states, error on unmapped addresses
    // =====================================================================
    assign addr = paddr[ADDR_W-1:0];
    assign addr_hit = paddr[31:ADDR_W] == '0 && (addr == CTRL_ADDR ||
        addr == STATUS_ADDR || addr == INT_STAT_ADDR ||
        addr == INT_MASK_ADDR);
    assign wr_access = psel && penable && pwrite && addr_hit;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    // writable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_off <= CTRL_SW_OFF_RESET;
            irq_mask <= IRQ_MASK_RESET;
        end else if (wr_access) begin
            if (addr == CTRL_ADDR) begin
                sw_off <= pwdata[CTRL_SW_OFF_BIT];
            end
            if (addr == INT_MASK_ADDR) begin
                irq_mask <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // read data is captured in the setup cycle, valid in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_setup) begin
            prdata <= '0;
            if (addr_hit) begin
                unique case (addr)
                    CTRL_ADDR: begin
                        prdata[CTRL_SW_OFF_BIT] <= sw_off;
                    end
                    STATUS_ADDR: begin
                        prdata[ST_STATE_LSB +: ST_STATE_W] <= state;
                        prdata[ST_POWER_OK_OUT_BIT] <= power_good;
                        prdata[ST_OT_BIT] <= ot_latched;
                        prdata[ST_OCP_BIT] <= ocp_holdoff;
                        prdata[ST_LEVEL_BIT] <=
                            power_stage.target_level_high;
                    end
                    INT_STAT_ADDR: begin
                        prdata[IRQ_W-1:0] <= irq_stat;
                    end
                    INT_MASK_ADDR: begin
                        prdata[IRQ_W-1:0] <= irq_mask;
                    end
                    default: begin
                        prdata <= '0;
                    end
                endcase
            end
        end
    end

    // =====================================================================
    // assertions
    // =====================================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence auto_run_s;
        run_ok && sense.uvlo_ok && force_pass_through_n;
    endsequence

    sequence fault_wait_s;
        state == st_fault && restart_due ##0 auto_run_s;
    endsequence

    // stage outputs sit at zero in reset, so skip the edge of release
    shutdown_force_a: assert property (
        !enable && $past(presetn) |=> state == st_shutdown &&
            power_stage.isolate_output &&
            !power_stage.switching_enable && !power_stage.bypass_switch_on)
        else $error("enable low did not force shutdown");

    start_entry_a: assert property (
        state == st_shutdown ##0 auto_run_s |=> state == st_linear_start_phase_one &&
            power_stage.linear_start_phase_one)
        else $error("startup did not enter linear phase one");

    phase_limit_a: assert property (
        state == st_linear_start_phase_two |-> power_stage.linear_start_phase_two &&
            !power_stage.linear_start_phase_one)
        else $error("phase two current limit wrong");

    startup_soft_a: assert property (
        state == st_startup ##0 auto_run_s |=> state == st_soft_start ##0
            power_stage.ref_ramp_enable)
        else $error("startup did not move to soft-start");

    linear_start_phase_two_timeout_a: assert property (
        state == st_linear_start_phase_two && timer == TIMER_W'(LINEAR_START_PHASE_TWO_TIMEOUT_CYCLES - 1) &&
            !sense.out_charged ##0 auto_run_s |=> state == st_fault)
        else $error("phase two timeout missed");

    soft_timeout_a: assert property (
        state == st_soft_start &&
            timer == TIMER_W'(SOFT_TIMEOUT_CYCLES - 1) &&
            !sense.out_in_regulation ##0 auto_run_s |=> state == st_fault)
        else $error("soft-start timeout missed");

    fault_restart_a: assert property (
        fault_wait_s |=> state == st_linear_start_phase_one && timer == TIMER_W'(0))
        else $error("fault restart wrong");

    fault_isolate_a: assert property (
        state == st_fault |-> power_stage.isolate_output &&
            !power_stage.bypass_switch_on)
        else $error("fault state not isolated");

    auto_bypass_a: assert property (
        state == st_boost && sense.input_above_target ##0 auto_run_s
            |=> state == st_bypass && power_stage.bypass_switch_on)
        else $error("boost did not hand over to bypass");

    pass_through_a: assert property (
        run_ok && sense.uvlo_ok && !force_pass_through_n |=>
            state == st_pass_through && power_stage.pass_through_limit &&
            !power_stage.switching_enable)
        else $error("forced pass-through not entered");

    level_follow_a: assert property (
        state inside {st_boost, st_bypass} |=>
            power_stage.target_level_high == $past(output_level_select))
        else $error("output level select not followed");

    power_ok_out_fault_a: assert property (
        state == st_fault || ocp_holdoff |=> !power_ok_out_oe_n)
        else $error("power good not pulled low on fault");

    power_ok_out_hot_a: assert property (
        sense.temp_above_rise |=> ot_latched ##1 !power_ok_out_oe_n)
        else $error("power good not low when hot");

    ocp_holdoff_a: assert property (
        sense.high_side_on && sense.overcurrent_detect |=> !hs_pulse_allow
            ##0 ocp_holdoff)
        else $error("overcurrent pulse not held off");

    ot_hold_a: assert property (
        ot_latched && !sense.temp_below_fall |=> ot_latched &&
            !power_stage.switching_enable)
        else $error("over-temperature latch released early");

endmodule

/* rtl/seq_pkg.sv */
// constants, types and register map for the boost/bypass mode sequencer
package seq_pkg;

    // =====================================================================
    // clock and timing
    // =====================================================================
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned LINEAR_START_PHASE_TWO_TIMEOUT_US = 1024;
    localparam int unsigned SOFT_TIMEOUT_MS = 2;
    localparam int unsigned RESTART_DELAY_MS = 1;
    localparam int unsigned NS_PER_US = 1000;
    localparam int unsigned NS_PER_MS = 1000000;
    // least times round up to whole cycles
    localparam int unsigned LINEAR_START_PHASE_TWO_TIMEOUT_CYCLES =
        (LINEAR_START_PHASE_TWO_TIMEOUT_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SOFT_TIMEOUT_CYCLES =
        (SOFT_TIMEOUT_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESTART_DELAY_CYCLES =
        (RESTART_DELAY_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W = 18;

    // =====================================================================
    // register map (byte addresses)
    // =====================================================================
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] INT_STAT_ADDR = 8'h08;
    localparam logic [7:0] INT_MASK_ADDR = 8'h0C;
    localparam int unsigned ADDR_W = 8;

    // control fields
    localparam int unsigned CTRL_SW_OFF_BIT = 0;
    localparam logic CTRL_SW_OFF_RESET = 1'b0;

    // status fields
    localparam int unsigned ST_STATE_LSB = 0;
    localparam int unsigned ST_STATE_W = 4;
    localparam int unsigned ST_POWER_OK_OUT_BIT = 4;
    localparam int unsigned ST_OT_BIT = 5;
    localparam int unsigned ST_OCP_BIT = 6;
    localparam int unsigned ST_LEVEL_BIT = 7;

    // interrupt status / mask layout
    localparam int unsigned IRQ_W = 5;
    localparam int unsigned IRQ_FAULT_BIT = 0;
    localparam int unsigned IRQ_PG_RISE_BIT = 1;
    localparam int unsigned IRQ_PG_FALL_BIT = 2;
    localparam int unsigned IRQ_OT_BIT = 3;
    localparam int unsigned IRQ_OCP_BIT = 4;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;

    // =====================================================================
    // types
    // =====================================================================
    typedef enum logic [3:0] {
        st_shutdown,
        st_linear_start_phase_one,
        st_linear_start_phase_two,
        st_startup,
        st_soft_start,
        st_boost,
        st_bypass,
        st_pass_through,
        st_fault
    } state_e;

    // analog comparator and sense results, synchronous to pclk
    typedef struct packed {
        logic uvlo_ok;            // input_supply above lockout level
        logic out_half_charged;   // output_supply charged enough for phase two
        logic out_charged;        // output_supply has reached input_supply
        logic ref_ramp_done;      // internal reference ramp finished
        logic out_in_regulation;  // output at its minimum target level
        logic input_above_target; // input_supply above target output
        logic high_side_on;       // high-side switch on time
        logic overcurrent_detect; // inductor current above overcurrent_limit
        logic temp_above_rise;    // die above 120 C
        logic temp_below_fall;    // die below 100 C
    } sense_s;

    // controls to the power stage
    typedef struct packed {
        logic linear_start_phase_one; // 1 A charging limit
        logic linear_start_phase_two; // 2 A charging limit
        logic switching_enable;       // converter switching allowed
        logic bypass_switch_on;       // bypass switch closed
        logic isolate_output;         // input and output at high impedance
        logic ref_ramp_enable;        // soft-start reference ramp running
        logic pass_through_limit;     // short-circuit limit near 4000 mA
        logic target_level_high;      // 1: 3.4 V target, 0: 3.2 V target
    } power_stage_s;

endpackage

/* test/boost_bypass_mode_sequencer_tb.sv */
// self-checking bench for the boost/bypass mode sequencer
`timescale 1ns/1ps
module boost_bypass_mode_sequencer_tb;
    import seq_pkg::*;
    // ================================================================
    // stimulus, partner and block
    // ================================================================
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, run = 1'b0, lvl = 1'b0, rerr;
    logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, hs_ok, pg_o, pg_oe_n, enable, fpt_n;
    sense_s sn = '0;
    power_stage_s ps;
    int err_count = 0, comparisons = 0, cyc = 0;
    // the power-good pin has an external pull-up
    wire pg_pin = pg_oe_n ? 1'b1 : pg_o;
    always #5 pclk = ~pclk;
    host_pins u_host (.pclk(pclk), .run(run), .enable(enable),
        .force_pass_through_n(fpt_n));
    // short timeouts keep the run brief
    boost_bypass_mode_sequencer #(.LINEAR_START_PHASE_TWO_TIMEOUT_CYCLES(20),
        .SOFT_TIMEOUT_CYCLES(40), .RESTART_DELAY_CYCLES(10)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .enable(enable),
        .force_pass_through_n(fpt_n), .output_level_select(lvl),
        .sense(sn), .power_stage(ps), .hs_pulse_allow(hs_ok),
        .power_ok_out_in(pg_pin), .power_ok_out_o(pg_o),
        .power_ok_out_oe_n(pg_oe_n), .irq(irq));
    // a hang ends the run as a failure
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end
    // ================================================================
    // shared tasks
    // ================================================================
    task automatic finish_test;
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    // one transfer; waits on pready, takes data at that same edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h00_0000, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so the next call never re-drives psel at once
        @(posedge pclk);
    endtask
    // an extra edge lets the state settle before the read is set up
    task automatic st(input state_e s);
        @(posedge pclk);
        apb(1'b0, STATUS_ADDR, 32'h0000_0000);
        chk(rd & 32'h0000_000f, {28'h000_0000, s});
    endtask
    // ================================================================
    // main sequence
    // ================================================================
    initial begin
        sn.uvlo_ok <= 1'b1;
        sn.temp_below_fall <= 1'b1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, INT_MASK_ADDR, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b1, INT_MASK_ADDR, 32'h0000_001f);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chkb(rerr, 1'b1);
        st(st_shutdown);
        run <= 1'b1;
        repeat (100) @(posedge pclk);
        st(st_pass_through);
        chkb(ps.bypass_switch_on & ps.pass_through_limit, 1'b1);
        chkb(ps.target_level_high, 1'b0);
        repeat (6000) @(posedge pclk);
        st(st_linear_start_phase_one);
        chkb(ps.linear_start_phase_one, 1'b1);
        sn.out_half_charged <= 1'b1;
        st(st_linear_start_phase_two);
        wait (ps.isolate_output === 1'b1);
        st(st_fault);
        chkb(irq, 1'b1);
        sn.out_charged <= 1'b1;
        wait (ps.switching_enable === 1'b1);
        st(st_soft_start);
        wait (ps.isolate_output === 1'b1);
        st(st_fault);
        apb(1'b1, INT_STAT_ADDR, 32'h0000_001f);
        repeat (2) @(posedge pclk);
        chkb(irq, 1'b0);
        sn.ref_ramp_done <= 1'b1;
        sn.out_in_regulation <= 1'b1;
        wait (ps.switching_enable === 1'b1);
        st(st_boost);
        chkb(pg_pin, 1'b1);
        apb(1'b0, INT_STAT_ADDR, 32'h0000_0000);
        chk(rd & 32'h0000_0002, 32'h0000_0002);
        sn.high_side_on <= 1'b1;
        sn.overcurrent_detect <= 1'b1;
        repeat (3) @(posedge pclk);
        chkb(hs_ok, 1'b0);
        chkb(pg_pin, 1'b0);
        sn.overcurrent_detect <= 1'b0;
        repeat (3) @(posedge pclk);
        chkb(hs_ok & pg_pin, 1'b1);
        sn.temp_above_rise <= 1'b1;
        sn.temp_below_fall <= 1'b0;
        repeat (3) @(posedge pclk);
        chkb(pg_pin | ps.switching_enable, 1'b0);
        sn.temp_above_rise <= 1'b0;
        repeat (3) @(posedge pclk);
        chkb(pg_pin, 1'b0);
        sn.temp_below_fall <= 1'b1;
        repeat (3) @(posedge pclk);
        chkb(pg_pin, 1'b1);
        sn.input_above_target <= 1'b1;
        lvl <= 1'b1;
        st(st_bypass);
        chkb(ps.bypass_switch_on & ps.target_level_high, 1'b1);
        // the software switch-off acts like enable low
        apb(1'b1, CTRL_ADDR, 32'h0000_0001);
        st(st_shutdown);
        apb(1'b1, CTRL_ADDR, 32'h0000_0000);
        run <= 1'b0;
        repeat (2) @(posedge pclk);
        st(st_shutdown);
        chkb(ps.bypass_switch_on | ps.switching_enable | pg_pin, 1'b0);
        finish_test();
    end
endmodule

/* test/host_pins.sv */
// host model driving the enable and bypass-select pins
`timescale 1ns/1ps
module host_pins #(
    parameter int unsigned SETTLE_CYCLES = 6000
) (
    input wire logic pclk,
    input wire logic run,
    output logic enable = 1'b0,
    output logic force_pass_through_n = 1'b0
);
    int unsigned dly = 0;
    // auto mode is asked for only after the enable settle time
    always @(posedge pclk) begin
        enable <= run;
        dly <= run ? dly + 1 : 0;
        force_pass_through_n <= run && dly >= SETTLE_CYCLES;
    end
endmodule
